// File: rtl/sdr_ctl.sv
// Purpose: Memory controller end driving the SDRAM command link
// Assumes: Single-word accesses, burst length one, auto precharge
// Notes:   Write data waits in a FIFO until its write command issues

// Purpose: Valid/ready FIFO with registered ready flag; valid decoded from the count
// Assumes: Depth is a power of two
// Notes:   Back-pressure shows on o_in_ready when full
module sdr_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   input  wire logic          i_sys_clk,
   input  wire logic          i_nrst,
   input  wire logic          i_in_valid,
   output logic               o_in_ready,
   input  wire logic [W-1:0]  i_in_data,
   output logic               o_out_valid,
   input  wire logic          i_out_ready,
   output logic [W-1:0]       o_out_data
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0]  mem;
      logic [AW-1:0]        wp;
      logic [AW-1:0]        rp;
      logic [AW:0]          cnt;
      logic                 rdy;
   } sdr_fifo_s;

   sdr_fifo_s               s;
   sdr_fifo_s               next_s;
   logic                    push;
   logic                    pop;

   always_comb begin
      next_s = s;
      push   = i_in_valid && s.rdy;
      pop    = (s.cnt != '0) && i_out_ready;
      if (push) begin
         next_s.mem[s.wp] = i_in_data;
         next_s.wp        = s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = s.rp + 1'b1;
      end
      next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
      next_s.rdy = next_s.cnt != FULL;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         s     <= '0;
         s.rdy <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign o_in_ready  = s.rdy;
   assign o_out_valid = s.cnt != '0;
   assign o_out_data  = s.mem[s.rp];
endmodule

module sdr_ctl
   import sdr_pkg::*;
(
   input  wire logic               i_sys_clk,
   input  wire logic               i_nrst,
   sdr_if.ctl                      bus,
   input  wire logic               i_req_valid,
   input  wire logic               i_req_wr,
   input  wire logic [ADDR_W-1:0]  i_req_addr,
   output logic                    o_req_ready,
   input  wire logic               i_wd_valid,
   input  wire logic [DW-1:0]      i_wd_data,
   output logic                    o_wd_ready,
   output logic                    o_rd_valid,
   output logic [DW-1:0]           o_rd_data,
   input  wire logic               i_sleep,
   output logic                    o_asleep
);

   typedef enum logic [7:0] {
      ST_INIT = 8'h01,
      ST_IDLE = 8'h02,
      ST_ACT  = 8'h04,
      ST_RCD  = 8'h08,
      ST_ACC  = 8'h10,
      ST_WAIT = 8'h20,
      ST_SREF = 8'h40,
      ST_REF  = 8'h80
   } sdr_st_e;

   typedef struct packed {
      sdr_st_e              st;
      logic [7:0]           cnt;
      logic [11:0]          refi;
      logic                 ref_due;
      logic                 wr;
      logic [ADDR_W-1:0]    addr;
      logic                 cs_n;
      sdr_cmd_e             cmd;
      logic                 cke;
      logic [BA_W-1:0]      ba;
      logic [MR_W-1:0]      a;
      logic [DW-1:0]        dq_o;
      logic                 dq_oe;
      logic [RD_LAT:0]      rd_sh;
      logic                 rd_v;
      logic [DW-1:0]        rd_d;
      logic                 req_rdy;
      logic                 asleep;
   } sdr_ctl_s;

   sdr_ctl_s                s;
   sdr_ctl_s                next_s;
   logic                    wd_v;
   logic [DW-1:0]           wd_d;
   logic                    wd_pop;

   sdr_fifo #(.W(DW), .D(FIFO_D)) u_wfifo (
      .i_sys_clk   (i_sys_clk),
      .i_nrst      (i_nrst),
      .i_in_valid  (i_wd_valid),
      .o_in_ready  (o_wd_ready),
      .i_in_data   (i_wd_data),
      .o_out_valid (wd_v),
      .i_out_ready (wd_pop),
      .o_out_data  (wd_d)
   );

   always_comb begin
      next_s       = s;
      wd_pop       = 1'b0;
      next_s.cs_n  = 1'b0;
      next_s.cmd   = CMD_NOP;
      next_s.dq_oe = 1'b0;
      next_s.rd_v  = 1'b0;
      next_s.rd_sh = {s.rd_sh[RD_LAT-1:0], 1'b0};
      // Device drives the word in the cycle before the latency edge
      if (s.rd_sh[RD_LAT]) begin
         next_s.rd_v = 1'b1;
         next_s.rd_d = bus.dq;
      end
      // Refresh interval timer; a new due beats a same-cycle clear
      next_s.refi = s.refi + 12'h001;
      if (s.refi == 12'(T_REFI_CYC - 1)) begin
         next_s.refi = 12'h000;
      end
      next_s.cnt = s.cnt - 8'h01;
      unique case (s.st)
         ST_INIT: begin
            next_s.cmd = CMD_MODE;
            next_s.a   = MODE_INIT;
            next_s.cnt = 8'(T_MRD_CYC - 1);
            next_s.st  = ST_WAIT;
         end
         ST_IDLE: begin
            if (s.req_rdy && i_req_valid) begin
               next_s.wr   = i_req_wr;
               next_s.addr = i_req_addr;
               next_s.st   = ST_ACT;
            end else if (i_sleep) begin
               next_s.cmd = CMD_REF;
               next_s.cke = 1'b0;
               next_s.st  = ST_SREF;
            end else if (s.ref_due) begin
               next_s.st = ST_REF;
            end
         end
         ST_REF: begin
            next_s.cmd     = CMD_REF;
            next_s.ref_due = 1'b0;
            next_s.cnt     = 8'(T_RFC_CYC - 1);
            next_s.st      = ST_WAIT;
         end
         ST_ACT: begin
            next_s.cmd = CMD_ACT;
            next_s.ba  = s.addr[ADDR_W-1 -: BA_W];
            next_s.a   = s.addr[COL_W +: ROW_W];
            next_s.cnt = 8'(T_RCD_CYC - 1);
            next_s.st  = ST_RCD;
         end
         ST_RCD: begin
            if (s.cnt == 8'h00) begin
               next_s.st = ST_ACC;
            end
         end
         ST_ACC: begin
            if (!s.wr || wd_v) begin
               next_s.cmd = s.wr ? CMD_WR : CMD_RD;
               next_s.a   = {{(MR_W-COL_W){1'b0}}, s.addr[COL_W-1:0]};
               next_s.a[AP_BIT] = 1'b1;
               next_s.dq_o  = wd_d;
               next_s.dq_oe = s.wr;
               wd_pop       = s.wr;
               next_s.rd_sh = {{RD_LAT{1'b0}}, !s.wr};
               next_s.cnt   = 8'(T_RC_CYC - 1);
               next_s.st    = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (s.cnt == 8'h00) begin
               next_s.st = ST_IDLE;
            end
         end
         ST_SREF: begin
            next_s.cs_n = 1'b1;
            if (!i_sleep) begin
               next_s.cs_n    = 1'b0;
               next_s.cke     = 1'b1;
               next_s.ref_due = 1'b1;
               next_s.cnt     = 8'(T_XSR_CYC - 1);
               next_s.st      = ST_WAIT;
            end
         end
      endcase
      if (s.refi == 12'(T_REFI_CYC - 1) && s.st != ST_SREF) begin
         next_s.ref_due = 1'b1;
      end
      next_s.asleep  = next_s.st == ST_SREF;
      next_s.req_rdy = (next_s.st == ST_IDLE) && !next_s.ref_due
                       && !i_sleep && !(s.st == ST_IDLE && s.req_rdy
                       && i_req_valid);
   end

   // Clock never changes rate; only clock enable throttles
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         s      <= '0;
         s.st   <= ST_INIT;
         s.cs_n <= 1'b1;
         s.cmd  <= CMD_NOP;
         s.cke  <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign bus.cs_n      = s.cs_n;
   assign bus.ras_n     = s.cmd[2];
   assign bus.cas_n     = s.cmd[1];
   assign bus.we_n      = s.cmd[0];
   assign bus.cke       = s.cke;
   assign bus.ba        = s.ba;
   assign bus.addr      = s.a;
   assign bus.dqm       = '0;
   assign bus.ctl_dq_o  = s.dq_o;
   assign bus.ctl_dq_oe = s.dq_oe;
   assign o_req_ready   = s.req_rdy;
   assign o_rd_valid    = s.rd_v;
   assign o_rd_data     = s.rd_d;
   assign o_asleep      = s.asleep;

endmodule

// File: shared/sdr_pkg.sv
// Purpose: Shared constants and types for the SDRAM command link
// Assumes: 200 MHz system clock on both ends
// Notes:   Times in ns; cycle counts other than T_MRD_CYC and RD_LAT derived from the clock period
package sdr_pkg;
   localparam int NBANK     = 4;
   localparam int ROWS      = 4096;
   localparam int COLS      = 256;
   localparam int DW        = 32;
   localparam int BA_W      = 2;
   localparam int ROW_W     = 12;
   localparam int COL_W     = 8;
   localparam int DM_W      = 4;
   localparam int MR_W      = 12;
   localparam int AP_BIT    = 10;
   localparam int MR_BL_LSB = 0;
   localparam int MR_BL_W   = 3;
   localparam int MEM_WORDS = NBANK * ROWS * COLS;
   localparam int ADDR_W    = BA_W + ROW_W + COL_W;
   localparam int FIFO_D    = 16;

   // Mode value loaded at start-up: burst of one, sequential
   localparam logic [MR_W-1:0] MODE_INIT  = 12'h020;
   localparam logic [MR_W-1:0] MODE_RESET = 12'h000;

   localparam int CLK_NS     = 5;
   localparam int T_RCD_NS   = 18;
   localparam int T_RC_NS    = 60;
   localparam int T_RFC_NS   = 60;
   localparam int T_XSR_NS   = 70;
   localparam int T_REFI_NS  = 15625;
   localparam int T_MRD_CYC  = 2;
   localparam int T_XSR_MIN  = 2;
   localparam int T_RCD_CYC  = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_RC_CYC   = (T_RC_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_RFC_CYC  = (T_RFC_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_XSR_CALC = (T_XSR_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_XSR_CYC  = T_XSR_CALC > T_XSR_MIN ? T_XSR_CALC
                                                      : T_XSR_MIN;
   localparam int T_REFI_CYC = T_REFI_NS / CLK_NS;
   localparam int RD_LAT     = 2;

   // Command code is {row strobe, column strobe, write strobe}
   typedef enum logic [2:0] {
      CMD_MODE = 3'h0,
      CMD_REF  = 3'h1,
      CMD_PRE  = 3'h2,
      CMD_ACT  = 3'h3,
      CMD_WR   = 3'h4,
      CMD_RD   = 3'h5,
      CMD_BST  = 3'h6,
      CMD_NOP  = 3'h7
   } sdr_cmd_e;
endpackage

// File: shared/sdr_if.sv
// Purpose: Command, address, mask and data wires between the two ends
// Assumes: Device drive wins a byte lane over controller drive
// Notes:   Undriven data lanes read as zero
interface sdr_if;
   import sdr_pkg::*;
   logic              cs_n;
   logic              ras_n;
   logic              cas_n;
   logic              we_n;
   logic              cke;
   logic [BA_W-1:0]   ba;
   logic [MR_W-1:0]   addr;
   logic [DM_W-1:0]   dqm;
   logic [DW-1:0]     ctl_dq_o;
   logic              ctl_dq_oe;
   logic [DW-1:0]     dev_dq_o;
   logic [DM_W-1:0]   dev_dq_oe;
   logic [DW-1:0]     dq;

   always_comb begin
      for (int b = 0; b < DM_W; b++) begin
         if (dev_dq_oe[b]) begin
            dq[b*8 +: 8] = dev_dq_o[b*8 +: 8];
         end else if (ctl_dq_oe) begin
            dq[b*8 +: 8] = ctl_dq_o[b*8 +: 8];
         end else begin
            dq[b*8 +: 8] = 8'h00;
         end
      end
   end

   modport dev (
      input  cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, dq,
      output dev_dq_o, dev_dq_oe
   );
   modport ctl (
      output cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm,
      output ctl_dq_o, ctl_dq_oe,
      input  dq
   );
endinterface

// File: rtl/sdr_dev.sv
// Purpose: Quad-bank single-data-rate SDRAM command and data end
// Assumes: All inputs synchronous to i_sys_clk
// Notes:   Read data leaves two clocks after its command or burst slot
//
// How it works
// - Inputs sampled on rising clock edge only
// - Four banks of 4096 rows, 256 columns
// - Activate: bank inputs pick bank, address row
// - Read/write: low eight address bits give column
// - Accesses are bursts of programmed length, sequential order only
// - Chip select high blocks new commands
// - All strobes high is a no-op
// - Strobe patterns decode into the seven commands
// - Refresh with clock enable low enters self refresh
// - Refresh row from internal counter, inputs ignored
// - Bit ten requests auto precharge, one command only
// - Auto precharge closes row after burst end
// - Precharge: bit ten high closes all banks
// - Mode load stores address as mode op-code
// - Controller loads mode only with banks idle
// - Controller precharges before opening another row
// - Read mask hides data byte two clocks later
// - Write mask discards byte with zero delay
// - Burst stop ends the current data burst
// - Controller keeps the clock rate constant
// - Controller issues 4096 refreshes per 64 ms
// - After self refresh exit, no-ops for exit time
module sdr_dev
   import sdr_pkg::*;
(
   input  wire logic               i_sys_clk,
   input  wire logic               i_nrst,
   sdr_if.dev                      bus,
   output logic [MR_W-1:0]         o_mode,
   output logic [NBANK-1:0]        o_open_banks,
   output logic                    o_self_refresh,
   output logic [ROW_W-1:0]        o_refresh_row
);

   typedef struct packed {
      logic [MR_W-1:0]              mode;
      logic [NBANK-1:0]             open;
      logic [NBANK-1:0][ROW_W-1:0]  row;
      logic                         act;
      logic                         wr;
      logic                         ap;
      logic [BA_W-1:0]              bank;
      logic [COL_W-1:0]             col;
      logic [COL_W-1:0]             left;
      logic                         sref;
      logic [ROW_W-1:0]             rcnt;
      logic                         p1_v;
      logic [DW-1:0]                p1_d;
      logic [DM_W-1:0]              p1_m;
      logic [DW-1:0]                dq_o;
      logic [DM_W-1:0]              dq_oe;
   } sdr_dev_s;

   sdr_dev_s                        s;
   sdr_dev_s                        next_s;
   sdr_cmd_e                        cmd;
   logic                            sel;
   logic                            acc_v;
   logic                            acc_wr;
   logic [BA_W-1:0]                 acc_bank;
   logic [COL_W-1:0]                acc_col;
   logic [COL_W-1:0]                blm;
   logic [ADDR_W-1:0]               idx;
   logic [DW-1:0]                   mem [0:MEM_WORDS-1];

   // Column step that wraps inside the burst-aligned block
   function automatic logic [COL_W-1:0] wrap(
      input logic [COL_W-1:0] c,
      input logic [COL_W-1:0] m
   );
      return (c & ~m) | ((c + 8'h01) & m);
   endfunction

   // Burst length minus one, from the mode field
   function automatic logic [COL_W-1:0] bl_mask(
      input logic [MR_W-1:0] md
   );
      logic [COL_W-1:0] r;
      r = 8'h00;
      case (md[MR_BL_LSB +: MR_BL_W])
         3'h1: r = 8'h01;
         3'h2: r = 8'h03;
         3'h3: r = 8'h07;
         3'h7: r = 8'hff;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   always_comb begin
      next_s   = s;
      cmd      = sdr_cmd_e'({bus.ras_n, bus.cas_n, bus.we_n});
      sel      = !bus.cs_n && !s.sref;
      acc_v    = 1'b0;
      acc_wr   = s.wr;
      acc_bank = s.bank;
      acc_col  = s.col;
      blm      = bl_mask(s.mode);

      // Burst continues unless a command below cuts it
      if (s.act) begin
         acc_v = 1'b1;
         if (s.left == 8'h00) begin
            next_s.act = 1'b0;
            if (s.ap) begin
               next_s.open[s.bank] = 1'b0;
            end
         end else begin
            next_s.left = s.left - 8'h01;
            next_s.col  = wrap(s.col, blm);
         end
      end

      if (sel) begin
         case (cmd)
            CMD_ACT: begin
               next_s.open[bus.ba] = 1'b1;
               next_s.row[bus.ba]  = bus.addr;
            end
            CMD_RD, CMD_WR: begin
               acc_v       = 1'b1;
               acc_wr      = (cmd == CMD_WR);
               acc_bank    = bus.ba;
               acc_col     = bus.addr[COL_W-1:0];
               next_s.wr   = acc_wr;
               next_s.ap   = bus.addr[AP_BIT];
               next_s.bank = bus.ba;
               next_s.act  = (blm != 8'h00);
               next_s.left = blm - 8'h01;
               next_s.col  = wrap(bus.addr[COL_W-1:0], blm);
               if (blm == 8'h00 && bus.addr[AP_BIT]) begin
                  next_s.open[bus.ba] = 1'b0;
               end
            end
            CMD_BST: begin
               next_s.act = 1'b0;
               acc_v      = 1'b0;
            end
            CMD_PRE: begin
               if (bus.addr[AP_BIT]) begin
                  next_s.open = '0;
                  next_s.act  = 1'b0;
               end else begin
                  next_s.open[bus.ba] = 1'b0;
                  if (bus.ba == s.bank) begin
                     next_s.act = 1'b0;
                  end
               end
            end
            CMD_REF: begin
               next_s.rcnt = s.rcnt + 12'h001;
               next_s.sref = !bus.cke;
            end
            CMD_MODE: begin
               next_s.mode = bus.addr;
            end
            default: begin
               next_s.act = next_s.act;
            end
         endcase
      end

      // Inputs other than clock enable ignored in self refresh
      if (s.sref && bus.cke) begin
         next_s.sref = 1'b0;
      end

      idx = {acc_bank, s.row[acc_bank], acc_col};

      // Two-stage read path keeps mask and data aligned
      next_s.p1_v  = acc_v && !acc_wr;
      next_s.p1_d  = mem[idx];
      next_s.p1_m  = bus.dqm;
      next_s.dq_o  = s.p1_d;
      next_s.dq_oe = s.p1_v ? ~s.p1_m : '0;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         s      <= '0;
         s.mode <= MODE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Write lands in the same cycle as its data and mask
   always_ff @(posedge i_sys_clk) begin
      if (acc_v && acc_wr) begin
         for (int b = 0; b < DM_W; b++) begin
            if (!bus.dqm[b]) begin
               mem[idx][b*8 +: 8] <= bus.dq[b*8 +: 8];
            end
         end
      end
   end

   assign bus.dev_dq_o   = s.dq_o;
   assign bus.dev_dq_oe  = s.dq_oe;
   assign o_mode         = s.mode;
   assign o_open_banks   = s.open;
   assign o_self_refresh = s.sref;
   assign o_refresh_row  = s.rcnt;

endmodule

// File: sim/sdr_link_checker.sv
// Purpose: Protocol checks on the command link between the two ends
// Assumes: Single clock domain, synchronous active-low reset
// Notes:   Watches the shared interface wires only
module sdr_link_checker
   import sdr_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_nrst,
   input  wire logic              cs_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic              cke,
   input  wire logic [MR_W-1:0]   addr,
   input  wire logic [DM_W-1:0]   dqm,
   input  wire logic              ctl_dq_oe,
   input  wire logic [DM_W-1:0]   dev_dq_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [2:0] cmd;

   assign cmd = {ras_n, cas_n, we_n};

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   sequence idle_s;
      cs_n || cmd == CMD_NOP;
   endsequence
   sequence rd_s;
      !cs_n && cmd == CMD_RD;
   endsequence
   sequence wr_s;
      !cs_n && cmd == CMD_WR;
   endsequence

   a_read_lane_on: assert property (
      rd_s ##0 dqm == 4'h0 |-> ##2 dev_dq_oe == 4'hf)
      else $error("read data lanes not driven two clocks after read");
   a_read_lane_off: assert property (
      dev_dq_oe != 4'h0 |-> $past(!cs_n && cmd == CMD_RD, 2))
      else $error("device drives data without a read");
   a_write_data_with: assert property (wr_s |-> ctl_dq_oe)
      else $error("write issued without its data");
   a_data_only_write: assert property (ctl_dq_oe |-> wr_s)
      else $error("controller drives data outside a write");
   a_mode_then_wait: assert property (
      !cs_n && cmd == CMD_MODE |=> idle_s)
      else $error("command issued inside mode load wait");
   a_act_then_wait: assert property (
      !cs_n && cmd == CMD_ACT |=> idle_s[*3])
      else $error("command issued inside activate wait");
   a_refresh_gap: assert property (
      !cs_n && cmd == CMD_REF && cke |=> idle_s[*8])
      else $error("command issued inside refresh period");
   a_exit_nop_run: assert property ($rose(cke) |-> idle_s[*8])
      else $error("command issued inside self refresh exit");
   a_auto_pre_set: assert property (
      !cs_n && (cmd == CMD_RD || cmd == CMD_WR) |-> addr[AP_BIT])
      else $error("access without auto precharge");
   a_sleep_cke_low: assert property (
      !cs_n && cmd == CMD_REF && !cke |=> (!cke)[*2])
      else $error("clock enable rose right after self refresh entry");
endmodule

// File: sim/tb_sdr_sdram_command_interface.sv
// Purpose: Self-checking bench joining controller and device ends
// Assumes: 200 MHz clock, inputs driven 1 ns after the rising edge
// Notes:   Checker instantiated beside the link interface
module tb_sdr_sdram_command_interface
   import sdr_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic              i_sys_clk;
   logic              i_nrst;
   logic              req_valid, req_wr, req_ready;
   logic [ADDR_W-1:0] req_addr;
   logic              wd_valid, wd_ready, rd_valid, sleep, asleep;
   logic [DW-1:0]     wd_data, rd_data;
   logic [MR_W-1:0]   mode;
   logic [NBANK-1:0]  open_banks;
   logic              self_ref;
   logic [ROW_W-1:0]  ref_row, r;
   int                err_count, check_count, cyc;
   localparam logic [ADDR_W-1:0] ADR [4] =
      '{22'h3fffff, 22'h000000, 22'h140080, 22'h20a55a};
   localparam logic [DW-1:0] DAT [4] =
      '{32'hffffffff, 32'h00000001, 32'h80000000, 32'ha5c35a3c};

   sdr_if bus_if ();
   sdr_dev sdr_dev_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
      .bus(bus_if), .o_mode(mode), .o_open_banks(open_banks),
      .o_self_refresh(self_ref), .o_refresh_row(ref_row));
   sdr_ctl sdr_ctl_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
      .bus(bus_if), .i_req_valid(req_valid), .i_req_wr(req_wr),
      .i_req_addr(req_addr), .o_req_ready(req_ready),
      .i_wd_valid(wd_valid), .i_wd_data(wd_data), .o_wd_ready(wd_ready),
      .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_sleep(sleep),
      .o_asleep(asleep));
   sdr_link_checker sdr_link_checker_inst (.i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst), .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n),
      .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .cke(bus_if.cke),
      .addr(bus_if.addr), .dqm(bus_if.dqm),
      .ctl_dq_oe(bus_if.ctl_dq_oe), .dev_dq_oe(bus_if.dev_dq_oe));

   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic final_report();
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end

   task automatic cmp(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask

   task automatic wait_hi(ref logic s);
      while (s !== 1'b1) tick(1);
   endtask

   task automatic push_wd(input logic [DW-1:0] d);
      wd_valid = 1'b1;
      wd_data  = d;
      wait_hi(wd_ready);
      tick(1);
      wd_valid = 1'b0;
      tick(1);
   endtask

   task automatic req(input logic wr, input logic [ADDR_W-1:0] a);
      req_valid = 1'b1;
      req_wr    = wr;
      req_addr  = a;
      wait_hi(req_ready);
      tick(1);
      req_valid = 1'b0;
      tick(1);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DW-1:0] e);
      req(1'b0, a);
      wait_hi(rd_valid);
      cmp(rd_data, e);
   endtask

   task automatic t_init();
      wait_hi(req_ready);
      cmp(DW'(mode), DW'(MODE_INIT));
      cmp(DW'(open_banks), 32'h0);
      cmp(DW'(self_ref), 32'h0);
   endtask

   task automatic t_rw();
      for (int i = 0; i < 4; i++) begin
         push_wd(DAT[i]);
         req(1'b1, ADR[i]);
      end
      for (int i = 0; i < 4; i++) rd_chk(ADR[i], DAT[i]);
      wait_hi(req_ready);
      cmp(DW'(open_banks), 32'h0);
   endtask

   task automatic t_fifo();
      for (int i = 0; i < FIFO_D; i++) push_wd(32'h10000000 + i);
      tick(1);
      cmp(DW'(wd_ready), 32'h0);
      for (int i = 0; i < FIFO_D; i++) req(1'b1, {2'h1, 12'h010, i[7:0]});
      for (int i = 0; i < FIFO_D; i++) begin
         rd_chk({2'h1, 12'h010, i[7:0]}, 32'h10000000 + i);
      end
      cmp(DW'(wd_ready), 32'h1);
   endtask

   task automatic t_sleep();
      r     = ref_row;
      sleep = 1'b1;
      wait_hi(asleep);
      // Device takes the entry command one edge later
      tick(1);
      cmp(DW'(self_ref), 32'h1);
      cmp(DW'(ref_row), DW'(r + 12'h001));
      tick(20);
      cmp(DW'(req_ready), 32'h0);
      sleep = 1'b0;
      wait_hi(req_ready);
      cmp(DW'(self_ref), 32'h0);
      cmp(DW'(ref_row), DW'(r + 12'h002));
      rd_chk(ADR[3], DAT[3]);
   endtask

   initial begin
      i_nrst    = 1'b0;
      req_valid = 1'b0;
      req_wr    = 1'b0;
      req_addr  = '0;
      wd_valid  = 1'b0;
      wd_data   = '0;
      sleep     = 1'b0;
      repeat (16) @(posedge i_sys_clk);
      #1;
      i_nrst = 1'b1;
      t_init();
      t_rw();
      t_fifo();
      t_sleep();
      final_report();
   end
endmodule
